// File: pcs_program_counter.sv
// file: program counter with upper latch and circular return stack
`timescale 1ns/10ps
module pcs_program_counter
  import pcs_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR_ADDR = VECTOR_ADDR_DEF
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire pcs_pkg::pcs_cmd_t cmd,
  input wire logic latch_wr,
  input wire logic [pcs_pkg::LOW_W-1:0] latch_wdata,
  output logic [pcs_pkg::PC_W-1:0] program_counter_ff,
  output logic [pcs_pkg::LOW_W-1:0] counter_low_byte_reg_ff,
  output logic [pcs_pkg::LOW_W-1:0] counter_upper_latch_ff
);
  import pcs_pkg::*;

  logic [PTR_W-1:0] ptr_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [PTR_W-1:0] nxt_ptr;
  logic push;
  logic [PC_W-1:0] pop_data;
  logic push_byp_ff;
  logic [PC_W-1:0] push_data_ff;
  logic [PC_W-1:0] top_entry;

  // address of the entry below the pointer
  function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
    ptr_dec = p - 3'h1;
  endfunction : ptr_dec

  // jump or call target: two latch bits over the eleven bit operand
  function automatic logic [PC_W-1:0] jump_target(
    input logic [LOW_W-1:0] lat,
    input logic [JUMP_W-1:0] opnd
  );
    jump_target = {lat[HIGH_W-1:JUMP_W-LOW_W], opnd};
  endfunction : jump_target

  // the top entry is prefetched each cycle, so a pop reads the memory
  // one cycle before the command; a push in that same cycle is not yet
  // in the prefetch, so the pushed value is bypassed below
  pcs_stack_mem #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH),
    .AW(PTR_W)
  ) u_mem (
    .mclk(mclk),
    .wr_en(push),
    .wr_addr(ptr_ff),
    .wr_data(program_counter_ff),
    .rd_addr(ptr_dec(nxt_ptr)),
    .rd_data_ff(pop_data)
  );

  // push only on call or vectoring
  // no push while reset is held, so the stack keeps its contents
  assign push = nrst && ((cmd.op == PCS_OP_CALL) ||
    (cmd.op == PCS_OP_VECTOR));

  // newest entry; the bypass covers a pop right after a push
  assign top_entry = push_byp_ff ? push_data_ff : pop_data;

  // next program counter
  always_comb begin
    nxt_pc = program_counter_ff;
    nxt_ptr = ptr_ff;
    unique case (cmd.op)
      PCS_OP_STEP: begin
        nxt_pc = program_counter_ff + 13'h0001;
      end
      PCS_OP_LOW_WRITE: begin
        nxt_pc = {counter_upper_latch_ff[HIGH_W-1:0], cmd.low_data};
      end
      PCS_OP_JUMP: begin
        nxt_pc = jump_target(counter_upper_latch_ff,
          cmd.jump_addr);
      end
      PCS_OP_CALL: begin
        nxt_pc = jump_target(counter_upper_latch_ff,
          cmd.jump_addr);
        nxt_ptr = ptr_ff + 3'h1;
      end
      PCS_OP_RETURN: begin
        nxt_pc = top_entry;
        nxt_ptr = ptr_dec(ptr_ff);
      end
      PCS_OP_VECTOR: begin
        nxt_pc = VECTOR_ADDR;
        nxt_ptr = ptr_ff + 3'h1;
      end
      PCS_OP_HOLD: begin
        nxt_pc = program_counter_ff;
      end
      default: begin
        nxt_pc = program_counter_ff;
      end
    endcase
  end

  // program counter and low byte view
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      program_counter_ff <= PC_RESET;
      counter_low_byte_reg_ff <= PC_RESET[LOW_W-1:0];
    end else begin
      program_counter_ff <= nxt_pc;
      counter_low_byte_reg_ff <= nxt_pc[LOW_W-1:0];
    end
  end

  // stack pointer, hidden from software
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ptr_ff <= PTR_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // upper latch, only written by its own strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      counter_upper_latch_ff <= LATCH_RESET;
    end else if (latch_wr) begin
      counter_upper_latch_ff <= latch_wdata;
    end
  end

  // remembers a push so that a pop on the next cycle sees it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      push_byp_ff <= 1'b0;
    end else begin
      push_byp_ff <= push;
    end
  end

  // copy of the counter from the previous cycle, the pushed value when push_byp_ff is set
  always_ff @(posedge mclk) begin
    push_data_ff <= program_counter_ff;
  end

  // assertions
  reset_clear_a: assert property (@(posedge mclk)
    !nrst |=> program_counter_ff == PC_RESET)
    else $error("counter not cleared by reset");

  ptr_reset_a: assert property (@(posedge mclk)
    !nrst |=> ptr_ff == PTR_RESET)
    else $error("pointer not cleared by reset");

  low_write_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_LOW_WRITE |=> program_counter_ff ==
      {$past(counter_upper_latch_ff[HIGH_W-1:0]), $past(cmd.low_data)})
    else $error("low byte write loaded wrong value");

  low_high_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_LOW_WRITE |=> program_counter_ff[PC_W-1:LOW_W] ==
      $past(counter_upper_latch_ff[HIGH_W-1:0]))
    else $error("low byte write carried into high bits");

  jump_load_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_JUMP |=> program_counter_ff ==
      {$past(counter_upper_latch_ff[HIGH_W-1:JUMP_W-LOW_W]),
      $past(cmd.jump_addr)})
    else $error("jump loaded wrong value");

  call_load_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_CALL |=>
      program_counter_ff[JUMP_W-1:0] == $past(cmd.jump_addr))
    else $error("call took wrong operand bits");

  vector_load_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_VECTOR |=> program_counter_ff == VECTOR_ADDR)
    else $error("vectoring went to wrong address");

  step_inc_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_STEP |=>
      program_counter_ff == $past(program_counter_ff) + 13'h0001)
    else $error("step did not advance counter");

  hold_keep_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_HOLD |=> $stable(program_counter_ff))
    else $error("hold changed the counter");

  call_ret_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_CALL ##1 cmd.op == PCS_OP_RETURN |=>
      program_counter_ff == $past(program_counter_ff, 2))
    else $error("return after call lost the pushed value");

  low_view_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    1 |-> counter_low_byte_reg_ff == program_counter_ff[LOW_W-1:0])
    else $error("low byte view mismatch");

  latch_keep_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    !latch_wr |=> $stable(counter_upper_latch_ff))
    else $error("latch changed without a write");

  push_ptr_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    push |=> ptr_ff == $past(ptr_ff) + 3'h1)
    else $error("push did not advance pointer");

  ptr_move_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    !push && cmd.op != PCS_OP_RETURN |=> $stable(ptr_ff))
    else $error("pointer moved without call or return");

  pop_ptr_a: assert property (@(posedge mclk)
    disable iff (!nrst)
    cmd.op == PCS_OP_RETURN |=> ptr_ff == $past(ptr_ff) - 3'h1)
    else $error("pop did not retreat pointer");
endmodule : pcs_program_counter

// File: pcs_pkg.sv
// package: program counter and return stack constants and types
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 5;
  localparam int JUMP_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
  localparam logic [LOW_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [PC_W-1:0] VECTOR_ADDR_DEF = 13'h0004;

  // one-cycle program-flow command from the decoder
  typedef enum logic [2:0] {
    PCS_OP_STEP,
    PCS_OP_LOW_WRITE,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RETURN,
    PCS_OP_VECTOR,
    PCS_OP_HOLD
  } pcs_op_t;

  // command carrier
  typedef struct packed {
    pcs_op_t op;
    logic [LOW_W-1:0] low_data;
    logic [JUMP_W-1:0] jump_addr;
  } pcs_cmd_t;
endpackage : pcs_pkg

// File: pcs_stack_mem.sv
// file: return address storage with registered read data
`timescale 1ns/10ps
module pcs_stack_mem #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_ff
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  // write port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge mclk) begin
    rd_data_ff <= mem_ff[rd_addr];
  end
endmodule : pcs_stack_mem

// File: pcs_decoder_model.sv
// decoder model: random program-flow commands and upper latch writes
`timescale 1ns/10ps
module pcs_decoder_model
  import pcs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  output pcs_pkg::pcs_cmd_t cmd,
  output logic latch_wr,
  output logic [pcs_pkg::LOW_W-1:0] latch_wdata
);
  integer seed = 19965;
  integer fill = 0;
  // quiet values at time zero
  initial begin
    cmd = '0;
    latch_wr = 1'b0;
    latch_wdata = 8'h00;
  end
  // calls fill the whole stack after reset, so no pop reads an empty slot
  always @(negedge mclk) begin
    if (!nrst) begin
      fill <= 0;
    end else if (fill < STACK_DEPTH) begin
      fill <= fill + 1;
    end
  end
  // new command each falling edge; only flow ops exist
  always @(negedge mclk) begin
    if (fill < STACK_DEPTH) begin
      cmd.op <= PCS_OP_CALL;
    end else begin
      cmd.op <= pcs_op_t'(3'($unsigned($random(seed)) % 7));
    end
    cmd.low_data <= 8'($random(seed));
    cmd.jump_addr <= 11'($random(seed));
    latch_wr <= 1'($random(seed));
    latch_wdata <= 8'($random(seed));
  end
endmodule : pcs_decoder_model

// File: pcs_program_counter_tb_top.sv
// testbench: random flow commands checked against a reference model
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module pcs_program_counter_tb_top;
  import pcs_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  pcs_cmd_t cmd;
  logic latch_wr;
  logic [LOW_W-1:0] latch_wdata;
  logic [PC_W-1:0] pc_o;
  logic [LOW_W-1:0] low_o;
  logic [LOW_W-1:0] lat_o;
  logic [PC_W-1:0] m_pc;
  logic [PC_W-1:0] m_stk [STACK_DEPTH];
  logic [LOW_W-1:0] m_lat;
  int m_ptr;
  int mismatches = 0;
  int check_count = 0;
  always #5 mclk = ~mclk;
  pcs_decoder_model u_dec (.mclk(mclk), .nrst(nrst), .cmd(cmd),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata));
  pcs_program_counter u_dut (.mclk(mclk), .nrst(nrst), .cmd(cmd),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata),
    .program_counter_ff(pc_o), .counter_low_byte_reg_ff(low_o),
    .counter_upper_latch_ff(lat_o));
  // reference model of counter, latch and circular stack
  always @(posedge mclk) begin
    if (!nrst) begin
      m_pc = PC_RESET;
      m_ptr = 0;
      m_lat = 8'h00;
    end else begin
      case (cmd.op)
        PCS_OP_STEP: m_pc = m_pc + 13'h0001;
        PCS_OP_LOW_WRITE: m_pc = {m_lat[4:0], cmd.low_data};
        PCS_OP_JUMP: m_pc = {m_lat[4:3], cmd.jump_addr};
        PCS_OP_CALL, PCS_OP_VECTOR: begin
          m_stk[m_ptr] = m_pc;
          m_ptr = (m_ptr + 1) % STACK_DEPTH;
          m_pc = (cmd.op == PCS_OP_CALL) ? {m_lat[4:3], cmd.jump_addr}
            : VECTOR_ADDR_DEF;
        end
        PCS_OP_RETURN: begin
          m_ptr = (m_ptr + 7) % STACK_DEPTH;
          m_pc = m_stk[m_ptr];
        end
        default: ;
      endcase
      if (latch_wr) m_lat = latch_wdata;
    end
  end
  // compare every result once the edge has settled
  always @(negedge mclk) begin
    `CHK("pc", m_pc, pc_o)
    `CHK("low", m_pc[7:0], low_o)
    `CHK("latch", m_lat, lat_o)
  end
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // reset, run, reset again in mid-run, run again
  initial begin
    repeat (10) @(negedge mclk);
    nrst <= 1'b1;
    repeat (3000) @(negedge mclk);
    nrst <= 1'b0;
    repeat (2) @(negedge mclk);
    nrst <= 1'b1;
    repeat (3000) @(negedge mclk);
    give_verdict();
  end
  // watchdog
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule : pcs_program_counter_tb_top
